// File: core/acr_host.sv
// Host controller reading three cascaded converters through one serial stream
`timescale 1ns/1ps
`default_nettype none
`include "acr_host_map.svh"

module acr_host
    import acr_pkg::*;
#(
    parameter int unsigned RECOVERY_CYCLES = `ACR_RECOVERY_CYC
) (
    // System
    input wire logic clk,
    input wire logic srst,
    // User control
    input wire logic runEn,
    input wire logic pdReq,
    input wire logic syncStart,
    // User results
    output logic [15:0] wordUp,
    output logic [15:0] wordMid,
    output logic [15:0] wordDown,
    output logic wordsValid,
    output logic recovering,
    output logic syncLocked,
    output logic muxStep,
    // Converter pins
    output logic convertN,
    output logic serialShiftClock,
    input wire logic [2:0] busyPin,
    input wire logic dataPin,
    output logic selectDriveFlag,
    output logic frameSyncDriveFlag,
    output logic powerDownRequest,
    output logic cascadeTie
);

    acr_rd_state_t rdState_ff;
    acr_rd_state_t nxt_rdState;
    acr_sync_state_t syncState_ff;
    logic [2:0] busySync1_ff;
    logic [2:0] busySync2_ff;
    logic dataSync1_ff;
    logic dataSync2_ff;
    logic compBusy;
    logic compBusyD_ff;
    logic busyRise;
    logic busyFall;
    logic [19:0] recCnt_ff;
    logic [9:0] convCnt_ff;
    logic convAllowed;
    logic [9:0] syncCnt_ff;
    logic [1:0] phase_ff;
    logic [5:0] bitIdx_ff;
    logic inBurst;
    logic startBurst;
    logic sampleNow;
    logic lastBit;
    logic [15:0] upSh_ff;
    logic [15:0] midSh_ff;
    logic [15:0] downSh_ff;
    logic [15:0] wordUp_ff;
    logic [15:0] wordMid_ff;
    logic [15:0] wordDown_ff;
    logic wordsValid_ff;
    logic muxStep_ff;
    logic convertN_ff;
    logic serialShiftClock_ff;
    logic powerDownRequest_ff;

    // Pin synchronisers
    always_ff @(posedge clk) begin
        if (srst) begin
            busySync1_ff <= 3'h7;
            busySync2_ff <= 3'h7;
            dataSync1_ff <= 1'b0;
            dataSync2_ff <= 1'b0;
        end else begin
            busySync1_ff <= busyPin;
            busySync2_ff <= busySync1_ff;
            dataSync1_ff <= dataPin;
            dataSync2_ff <= dataSync1_ff;
        end
    end

    // Composite busy and its edges
    assign compBusy = |busySync2_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            compBusyD_ff <= 1'b1;
        end else begin
            compBusyD_ff <= compBusy;
        end
    end

    assign busyRise = compBusy & ~compBusyD_ff;
    assign busyFall = ~compBusy & compBusyD_ff;

    // Power-down and recovery; conversions wait out the settling time
    always_ff @(posedge clk) begin
        if (srst) begin
            powerDownRequest_ff <= 1'b0;
            recCnt_ff <= 20'h0;
        end else begin
            powerDownRequest_ff <= pdReq;
            if (powerDownRequest_ff) begin
                recCnt_ff <= RECOVERY_CYCLES[19:0];
            end else if (recCnt_ff != 20'h0) begin
                recCnt_ff <= recCnt_ff - 20'h1;
            end
        end
    end

    assign convAllowed = runEn & ~powerDownRequest_ff & (recCnt_ff == 20'h0);

    // Convert timer; one trigger drives all converters so they sample together
    always_ff @(posedge clk) begin
        if (srst) begin
            convCnt_ff <= 10'h0;
            convertN_ff <= 1'b1;
        end else begin
            if (!convAllowed || convCnt_ff == `ACR_CONV_PERIOD - 10'h1) begin
                convCnt_ff <= 10'h0;
            end else begin
                convCnt_ff <= convCnt_ff + 10'h1;
            end
            convertN_ff <= ~(convAllowed && convCnt_ff < `ACR_CONV_LOW);
        end
    end

    // Frame sync start-up sequence, restarted on request
    always_ff @(posedge clk) begin
        if (srst || syncStart) begin
            syncState_ff <= SY_DISCARD;
            syncCnt_ff <= 10'h0;
        end else begin
            unique case (syncState_ff)
                SY_DISCARD: begin
                    if (syncCnt_ff == `ACR_CONV_PERIOD - 10'h1) begin
                        syncState_ff <= SY_DESEL;
                        syncCnt_ff <= 10'h0;
                    end else begin
                        syncCnt_ff <= syncCnt_ff + 10'h1;
                    end
                end
                SY_DESEL: begin
                    if (syncCnt_ff == `ACR_CONV_PERIOD - 10'h1) begin
                        syncState_ff <= SY_LOCKED;
                        syncCnt_ff <= 10'h0;
                    end else begin
                        syncCnt_ff <= syncCnt_ff + 10'h1;
                    end
                end
                SY_LOCKED: begin
                    syncCnt_ff <= 10'h0;
                end
                default: begin
                    syncState_ff <= SY_DISCARD;
                    syncCnt_ff <= 10'h0;
                end
            endcase
        end
    end

    // Active-high frame sync stays low until the port is aligned
    assign frameSyncDriveFlag = (syncState_ff == SY_LOCKED);
    assign selectDriveFlag = (syncState_ff == SY_DESEL);
    assign syncLocked = (syncState_ff == SY_LOCKED);

    // Readout sequencing around composite busy edges
    assign inBurst = (rdState_ff == RD_UP) || (rdState_ff == RD_DOWN);
    assign sampleNow = inBurst && (phase_ff == `ACR_PHASE_LAST);
    assign lastBit = (rdState_ff == RD_UP) ? (bitIdx_ff == `ACR_UP_PULSES - 6'd1)
                                           : (bitIdx_ff == `ACR_DOWN_PULSES - 6'd1);
    assign startBurst = ((rdState_ff == RD_IDLE) && busyRise && runEn)
                      || ((rdState_ff == RD_WAIT_FALL) && busyFall && runEn);

    always_comb begin
        nxt_rdState = rdState_ff;
        unique case (rdState_ff)
            RD_IDLE: begin
                if (busyRise && runEn) begin
                    nxt_rdState = RD_UP;
                end
            end
            RD_UP: begin
                if (sampleNow && lastBit) begin
                    nxt_rdState = RD_WAIT_FALL;
                end
            end
            RD_WAIT_FALL: begin
                if (!runEn) begin
                    nxt_rdState = RD_IDLE;
                end else if (busyFall) begin
                    nxt_rdState = RD_DOWN;
                end
            end
            RD_DOWN: begin
                if (sampleNow && lastBit) begin
                    nxt_rdState = RD_IDLE;
                end
            end
            default: begin
                nxt_rdState = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdState_ff <= RD_IDLE;
        end else begin
            rdState_ff <= nxt_rdState;
        end
    end

    // Shift clock generator: idle low, high for two cycles of each pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_ff <= 2'h0;
            bitIdx_ff <= 6'h0;
            serialShiftClock_ff <= 1'b0;
        end else begin
            if (startBurst) begin
                phase_ff <= 2'h0;
                bitIdx_ff <= 6'h0;
            end else if (inBurst) begin
                phase_ff <= phase_ff + 2'h1;
                if (sampleNow) begin
                    bitIdx_ff <= bitIdx_ff + 6'h1;
                end
            end else begin
                phase_ff <= 2'h0;
            end
            serialShiftClock_ff <= startBurst
                || (inBurst && phase_ff < `ACR_PHASE_HIGH_END)
                || (sampleNow && !lastBit);
        end
    end

    // Data capture: sampled three cycles after the rising edge so the output delay has settled
    always_ff @(posedge clk) begin
        if (srst) begin
            upSh_ff <= 16'h0;
            midSh_ff <= 16'h0;
            downSh_ff <= 16'h0;
        end else if (sampleNow) begin
            if (rdState_ff == RD_UP) begin
                if (bitIdx_ff < `ACR_WORD_BITS) begin
                    upSh_ff <= {upSh_ff[14:0], dataSync2_ff};
                end else if (bitIdx_ff > `ACR_NULL_IDX && bitIdx_ff <= `ACR_MID_LAST_IDX) begin
                    midSh_ff <= {midSh_ff[14:0], dataSync2_ff};
                end
            end else if (bitIdx_ff < `ACR_WORD_BITS) begin
                downSh_ff <= {downSh_ff[14:0], dataSync2_ff};
            end
        end
    end

    // Words handed out once per conversion, only after the port is aligned
    always_ff @(posedge clk) begin
        if (srst) begin
            wordUp_ff <= 16'h0;
            wordMid_ff <= 16'h0;
            wordDown_ff <= 16'h0;
            wordsValid_ff <= 1'b0;
        end else begin
            wordsValid_ff <= 1'b0;
            if (rdState_ff == RD_DOWN && sampleNow && lastBit && syncLocked) begin
                wordUp_ff <= upSh_ff;
                wordMid_ff <= midSh_ff;
                wordDown_ff <= downSh_ff;
                wordsValid_ff <= 1'b1;
            end
        end
    end

    // Multiplexer step right after conversion completes
    always_ff @(posedge clk) begin
        if (srst) begin
            muxStep_ff <= 1'b0;
        end else begin
            muxStep_ff <= busyRise;
        end
    end

    assign wordUp = wordUp_ff;
    assign wordMid = wordMid_ff;
    assign wordDown = wordDown_ff;
    assign wordsValid = wordsValid_ff;
    assign muxStep = muxStep_ff;
    assign convertN = convertN_ff;
    assign serialShiftClock = serialShiftClock_ff;
    assign powerDownRequest = powerDownRequest_ff;
    assign recovering = (recCnt_ff != 20'h0);
    assign cascadeTie = 1'b0;

    // Helper: shift pulses issued in the current burst
    logic [5:0] riseCnt_ff;
    always_ff @(posedge clk) begin
        if (srst || startBurst) begin
            riseCnt_ff <= 6'h0;
        end else if (serialShiftClock_ff && !$past(serialShiftClock_ff)) begin
            riseCnt_ff <= riseCnt_ff + 6'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    chk_up_start: assert property (rdState_ff == RD_IDLE && busyRise && runEn |=> rdState_ff == RD_UP && serialShiftClock)
        else $error("upstream burst did not start on busy rise");
    chk_down_start: assert property (rdState_ff == RD_WAIT_FALL && busyFall && runEn |=> rdState_ff == RD_DOWN)
        else $error("downstream burst did not start on busy fall");
    chk_up_pulses: assert property ($fell(rdState_ff == RD_UP) |-> riseCnt_ff == 6'd34)
        else $error("upstream burst pulse count wrong");
    chk_down_pulses: assert property ($fell(rdState_ff == RD_DOWN) |-> riseCnt_ff == 6'd17)
        else $error("downstream burst pulse count wrong");
    chk_clock_idle_low: assert property (!inBurst |-> !serialShiftClock)
        else $error("shift clock high outside a burst");
    chk_null_dropped: assert property (sampleNow && rdState_ff == RD_UP && bitIdx_ff == 6'd16
                                       |=> $stable(upSh_ff) && $stable(midSh_ff))
        else $error("null bit was stored");
    chk_convert_pulse: assert property ($fell(convertN) |-> !convertN [*2] ##1 convertN)
        else $error("convert pulse width wrong");
    chk_recovery_hold: assert property ($fell(powerDownRequest) |-> recovering ##1 convertN [*8])
        else $error("conversion started during recovery");
    chk_sync_order: assert property ($rose(frameSyncDriveFlag) |-> !selectDriveFlag && $past(selectDriveFlag))
        else $error("frame sync raised out of order");
    chk_sync_discard: assert property (syncState_ff != SY_LOCKED |-> !wordsValid)
        else $error("words delivered before alignment");
    chk_tag_tied: assert property (!cascadeTie)
        else $error("cascade input not tied low");

    cov_up_burst: cover property ($fell(rdState_ff == RD_UP));
    cov_words: cover property (wordsValid);
    cov_locked: cover property ($rose(syncLocked));
    cov_recovered: cover property ($fell(recovering));

endmodule : acr_host

`default_nettype wire

// File: core/acr_host_map.svh
// Constants for the cascaded converter readout controller
`ifndef ACR_HOST_MAP_SVH
`define ACR_HOST_MAP_SVH

// System clock
`define ACR_CLK_PERIOD_NS 40
// Shift clock: one pulse is 4 system cycles, high in phases 0 and 1
`define ACR_PHASE_LAST 2'd3
`define ACR_PHASE_HIGH_END 2'd1
// Pulse counts per burst
`define ACR_UP_PULSES 6'd34
`define ACR_DOWN_PULSES 6'd17
// Bit positions inside the post-conversion burst
`define ACR_WORD_BITS 6'd16
`define ACR_NULL_IDX 6'd16
`define ACR_MID_LAST_IDX 6'd32
// Convert timer
`define ACR_CONV_PERIOD 10'd625
`define ACR_CONV_LOW 10'd2
// Power-up recovery, least time rounded up to whole cycles
`define ACR_RECOVERY_NS 1000000
`define ACR_RECOVERY_CYC ((`ACR_RECOVERY_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)

`endif

// File: core/acr_pkg.sv
// Types for the cascaded converter readout controller
package acr_pkg;

    typedef enum logic [3:0] {
        RD_IDLE      = 4'b0001,
        RD_UP        = 4'b0010,
        RD_WAIT_FALL = 4'b0100,
        RD_DOWN      = 4'b1000
    } acr_rd_state_t;

    typedef enum logic [2:0] {
        SY_DISCARD = 3'b001,
        SY_DESEL   = 3'b010,
        SY_LOCKED  = 3'b100
    } acr_sync_state_t;

endpackage : acr_pkg

// File: verif/acr_conv_model.sv
// Behavioural model of three cascaded converters on one shared shift clock
`timescale 1ns/1ps
`default_nettype none
module acr_conv_model #(
    parameter int CONV_NS = 4800
) (
    // Controls from the host
    input wire logic convertN,
    input wire logic serialShiftClock,
    input wire logic powerDownRequest,
    input wire logic selectDriveFlag,
    // Converter outputs
    output logic [2:0] busyPin,
    output logic dataPin,
    // Observation for the bench
    output logic [15:0] resUp,
    output logic [15:0] resMid,
    output logic [15:0] resDown,
    output int nPulseUp,
    output int nPulseDown
);
    logic [33:0] stream;
    int idx;
    int nConv;
    initial begin
        busyPin = 3'h7;
        dataPin = 1'b0;
        resUp = 16'h0;
        resMid = 16'h0;
        resDown = 16'h0;
        stream = 34'h0;
        idx = 0;
        nConv = 0;
        nPulseUp = 0;
        nPulseDown = 0;
    end
    // External clock mode, cascade path in use
    always @(negedge convertN) begin
        if (!powerDownRequest && busyPin === 3'h7) begin
            // Downstream word still holds the last result early in the conversion
            stream = {resDown, ~resDown[0], 17'h0};
            idx = 0;
            nPulseDown = 0;
            #7 busyPin = 3'h0;
            #(CONV_NS);
            nConv++;
            resUp = 16'h8a51 ^ 16'(nConv * 37);
            resMid = 16'h3c96 + 16'(nConv * 101);
            resDown = 16'hf00d ^ 16'(nConv * 613);
            // Null bit is the inverse of its neighbour, so keeping it corrupts a word
            stream = {resUp, ~resUp[0], resMid, ~resMid[0]};
            idx = 0;
            nPulseUp = 0;
            busyPin = 3'h7;
        end
    end
    // Data changes after the rising shift edge; a released line keeps flipping
    always @(posedge serialShiftClock) begin
        if (busyPin === 3'h7)
            nPulseUp++;
        else
            nPulseDown++;
        if (selectDriveFlag || idx > 33)
            dataPin <= #20 ~dataPin;
        else
            dataPin <= #20 stream[33 - idx];
        idx++;
    end
endmodule : acr_conv_model
`default_nettype wire

// File: verif/acr_host_tb.sv
// Self-checking bench for the cascaded converter readout controller
`timescale 1ns/1ps
`default_nettype none
`include "acr_host_map.svh"
module acr_host_tb;
    // Short recovery keeps the run brief
    localparam int RCV = 20;
    localparam int PER = 32'(`ACR_CONV_PERIOD);
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic runEn = 1'b0;
    logic pdReq = 1'b0;
    logic syncStart = 1'b0;
    logic [15:0] wordUp, wordMid, wordDown, resUp, resMid, resDown;
    logic wordsValid, recovering, syncLocked, muxStep, convertN, serialShiftClock;
    logic [2:0] busyPin;
    logic dataPin, selectDriveFlag, frameSyncDriveFlag, powerDownRequest, cascadeTie;
    int nPulseUp, nPulseDown;
    int nErrors = 0;
    int samplesChecked = 0;

    always #(`ACR_CLK_PERIOD_NS / 2) clk = ~clk;

    acr_host #(.RECOVERY_CYCLES(RCV)) i_dut (.clk(clk), .srst(srst), .runEn(runEn), .pdReq(pdReq),
        .syncStart(syncStart), .wordUp(wordUp), .wordMid(wordMid), .wordDown(wordDown),
        .wordsValid(wordsValid), .recovering(recovering), .syncLocked(syncLocked), .muxStep(muxStep),
        .convertN(convertN), .serialShiftClock(serialShiftClock), .busyPin(busyPin), .dataPin(dataPin),
        .selectDriveFlag(selectDriveFlag), .frameSyncDriveFlag(frameSyncDriveFlag),
        .powerDownRequest(powerDownRequest), .cascadeTie(cascadeTie));

    acr_conv_model i_model (.convertN(convertN), .serialShiftClock(serialShiftClock),
        .powerDownRequest(powerDownRequest), .selectDriveFlag(selectDriveFlag), .busyPin(busyPin),
        .dataPin(dataPin), .resUp(resUp), .resMid(resMid), .resDown(resDown),
        .nPulseUp(nPulseUp), .nPulseDown(nPulseDown));

    task automatic compareVal(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compareVal

    task automatic compareBit(input logic got, input logic exp);
        samplesChecked++;
        if (got !== exp) begin
            nErrors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : compareBit

    task automatic endOfTest();
        $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : endOfTest

    task automatic resetPhase();
        // Third edge with reset high is the one that releases it
        repeat (2) @(posedge clk);
        @(negedge clk);
        compareBit(convertN, 1'b1);
        compareBit(serialShiftClock, 1'b0);
        compareBit(cascadeTie, 1'b0);
        compareBit(powerDownRequest, 1'b0);
        compareBit(frameSyncDriveFlag, 1'b0);
        compareBit(wordsValid, 1'b0);
        @(posedge clk);
        srst <= 1'b0;
        runEn <= 1'b1;
    endtask : resetPhase

    // Discard phase, deselect phase, then locked with framing on
    task automatic syncCheck();
        int n;
        for (n = 0; n < 2000 && selectDriveFlag !== 1'b1; n++) @(negedge clk);
        compareBit(n >= PER - 1, 1'b1);
        compareBit(frameSyncDriveFlag, 1'b0);
        for (n = 0; n < 2000 && frameSyncDriveFlag !== 1'b1; n++) @(negedge clk);
        compareVal(n, PER);
        compareBit(selectDriveFlag, 1'b0);
        compareBit(syncLocked, 1'b1);
    endtask : syncCheck

    task automatic convertCheck();
        int n;
        for (n = 0; n < 700 && convertN !== 1'b0; n++) @(negedge clk);
        for (n = 0; n < 10 && convertN !== 1'b1; n++) @(negedge clk);
        compareVal(n, 32'(`ACR_CONV_LOW));
        for (; n < 700 && convertN !== 1'b0; n++) @(negedge clk);
        compareVal(n, PER);
    endtask : convertCheck

    task automatic readoutCheck();
        int n;
        for (n = 0; n < 1500 && muxStep !== 1'b1; n++) @(negedge clk);
        compareBit(|busyPin, 1'b1);
        compareBit(nPulseUp <= 1, 1'b1);
        @(negedge clk);
        compareBit(muxStep, 1'b0);
        for (n = 0; n < 1500 && wordsValid !== 1'b1; n++) @(negedge clk);
        compareVal(32'(wordUp), 32'(resUp));
        compareVal(32'(wordMid), 32'(resMid));
        compareVal(32'(wordDown), 32'(resDown));
        compareVal(nPulseUp, 32'(`ACR_UP_PULSES));
        compareVal(nPulseDown, 32'(`ACR_DOWN_PULSES));
        compareBit(syncLocked, 1'b1);
        compareBit(serialShiftClock, 1'b0);
    endtask : readoutCheck

    task automatic powerDownCheck();
        int n;
        logic bad;
        bad = 1'b0;
        @(posedge clk);
        pdReq <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        compareBit(powerDownRequest, 1'b1);
        repeat (3) @(negedge clk);
        for (n = 0; n < 700; n++) begin
            @(negedge clk);
            if (convertN !== 1'b1) bad = 1'b1;
        end
        compareBit(bad, 1'b0);
        @(posedge clk);
        pdReq <= 1'b0;
        // Recovery counts from the registered request falling, not from pdReq
        for (n = 0; n < 5 && powerDownRequest !== 1'b0; n++) @(negedge clk);
        compareBit(recovering, 1'b1);
        for (n = 0; n < 100 && recovering === 1'b1; n++) begin
            if (convertN !== 1'b1) bad = 1'b1;
            @(negedge clk);
        end
        compareBit(n >= RCV && n <= RCV + 1, 1'b1);
        compareBit(bad, 1'b0);
    endtask : powerDownCheck

    task automatic resyncCheck();
        @(posedge clk);
        syncStart <= 1'b1;
        @(posedge clk);
        syncStart <= 1'b0;
        @(negedge clk);
        compareBit(syncLocked, 1'b0);
        compareBit(frameSyncDriveFlag, 1'b0);
        syncCheck();
    endtask : resyncCheck

    initial begin
        resetPhase();
        syncCheck();
        convertCheck();
        readoutCheck();
        readoutCheck();
        powerDownCheck();
        readoutCheck();
        resyncCheck();
        readoutCheck();
        endOfTest();
    end

    // Whole run needs about 6500 cycles
    initial begin
        #(`ACR_CLK_PERIOD_NS * 20000);
        nErrors++;
        endOfTest();
    end
endmodule : acr_host_tb
`default_nettype wire
